// ===== core/pca_pwm_defines.svh
`ifndef PCA_PWM_DEFINES_SVH
`define PCA_PWM_DEFINES_SVH

// Special-function register addresses
`define CTRL_ADDR 8'hD8
`define PWMCFG_ADDR 8'hF7
`define CLRCFG_ADDR 8'h9C
`define ALIGN_ADDR 8'h9D
`define CPM0_ADDR 8'hDA
`define CPM1_ADDR 8'hDB
`define CPM2_ADDR 8'hDC
`define CPL0_ADDR 8'hFB
`define CPH0_ADDR 8'hFC
`define CPL1_ADDR 8'hE9
`define CPH1_ADDR 8'hEA
`define CPL2_ADDR 8'hEB
`define CPH2_ADDR 8'hEC
// Bit space: bit address upper five bits that select the control register
`define CTRL_BIT_BASE 5'h1B

// Field positions
`define CTRL_CF_BIT 7
`define CTRL_CR_BIT 6
`define PWM_RELOAD_VIEW_SELECT_BIT 7
`define PWM_ECOV_BIT 6
`define PWM_CYCLE_OVERFLOW_FLAG_BIT 5
`define CPM_WIDE_BIT 7
`define CPM_ECOM_BIT 6
`define CPM_MAT_BIT 3
`define CPM_PWM_BIT 1
`define CPM_ECCF_BIT 0
`define CLR_POL_BIT 7

// Reset values
`define BYTE_RST 8'h00
`define WORD_RST 16'h0000
`define CTR_RST 17'h00000

// Resolutions in bits
`define RES_BASE 5'h08
`define RES_WIDE 5'h10

`endif

// ===== core/pca_pwm_pkg.sv
package pca_pwm_pkg;

  typedef logic [7:0] sfr_byte_t;
  typedef logic [15:0] cmp_word_t;
  typedef logic [4:0] res_t;

  // Low-bit mask for an N-bit resolution, N from 8 to 16
  function automatic cmp_word_t res_mask(input res_t res);
    logic [16:0] m;
    m = (17'h00001 << res) - 17'h00001;
    return m[15:0];
  endfunction : res_mask

endpackage : pca_pwm_pkg

// ===== core/pwm_channel.sv
`timescale 1ns/1ps
`include "pca_pwm_defines.svh"

module pwm_channel
  import pca_pwm_pkg::*;
(
  input wire logic clk_i,          // System clock
  input wire logic rst_b_i,        // Async reset, active low
  input wire logic tick_i,         // Counter advances this cycle
  input wire logic [16:0] cnt_nxt_i, // Counter value after the advance
  input wire res_t res_i,          // Resolution in bits
  input wire logic match_en_i,     // Compare and PWM enabled
  input wire logic pwm_en_i,       // PWM enabled
  input wire logic center_i,       // Center-aligned operation
  input wire cmp_word_t cp_i,      // Compare value
  input wire logic clr_en_i,       // Comparator clear enabled
  input wire logic clr_pol_i,      // Clear edge polarity
  input wire logic cmp_level_i,    // Synchronised comparator level
  input wire logic cmp_rise_i,     // Comparator rising edge
  input wire logic cmp_fall_i,     // Comparator falling edge
  output logic set_ev_o,           // Match or up edge
  output logic clr_ev_o,           // Overflow or down edge
  output logic out_o               // Channel output
);

  cmp_word_t mask;
  cmp_word_t cnt_low;
  cmp_word_t cp_low;
  cmp_word_t prev_low;
  logic sel_bit;
  logic cyc_start;
  logic trig;
  logic active;
  logic hold_r;
  logic hold_nxt;
  logic out_r;

  always_comb begin
    mask = res_mask(res_i);
    cnt_low = cnt_nxt_i[15:0] & mask;
    cp_low = cp_i & mask;
    prev_low = (cnt_nxt_i[15:0] - 16'h0001) & mask;
    sel_bit = cnt_nxt_i[res_i];
    if (center_i) begin
      set_ev_o = tick_i && match_en_i && !sel_bit && (cp_low == prev_low);
      clr_ev_o = tick_i && pwm_en_i && sel_bit && ((~cp_i & mask) == cnt_low);
    end else begin
      set_ev_o = tick_i && match_en_i && (cp_low == cnt_low);
      clr_ev_o = tick_i && pwm_en_i && (cnt_low == 16'h0000);
    end
    cyc_start = tick_i && (cnt_low == 16'h0000) && (!center_i || !sel_bit);
    trig = clr_en_i && (clr_pol_i ? cmp_rise_i : cmp_fall_i);
    active = clr_pol_i ? cmp_level_i : !cmp_level_i;
    if (!clr_en_i) begin
      hold_nxt = 1'b0;
    end else if (trig) begin
      hold_nxt = 1'b1;
    end else if (cyc_start) begin
      hold_nxt = active;
    end else begin
      hold_nxt = hold_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // Set beats clear so that a zero compare value gives full duty in edge-aligned mode
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_r <= 1'b0;
    end else if (!pwm_en_i || hold_nxt) begin
      out_r <= 1'b0;
    end else if (set_ev_o) begin
      out_r <= 1'b1;
    end else if (clr_ev_o) begin
      out_r <= 1'b0;
    end
  end

  assign out_o = out_r;

endmodule : pwm_channel

// ===== core/pwm_top.sv
`timescale 1ns/1ps
`include "pca_pwm_defines.svh"

// Contract
// - Narrow PWM duty uses only the low N compare bits.
// - Reload view select steers compare byte addresses to reload registers.
// - Reload value copies into compare at overflow or up edge.
// - Compare, PWM enabled and length zero select 8-bit PWM.
// - Compare, PWM enabled and other length select 8 to 11-bit PWM, 8 plus length bits 1:0 (length 4 gives 8 bits).
// - Match flag enable sets event flag on match or up edge.
// - Narrow modes raise cycle overflow flag at overflow or down edge.
// - Low byte write clears compare enable; high byte write sets it.
// - Wide select runs a channel in 16-bit PWM with full compare.
// - Wide PWM signals overflow or down edge on counter overflow flag.
// - Counter wrap sets sticky overflow flag and requests interrupt if enabled.
// - Match sets channel flags 2..0, sticky, interrupt when enabled.
// - Counter run bit stops the counter at 0, counts at 1.
// - Control register sits at 0xD8 with single-bit access.
// - Comparator clear forces enabled channel low for current cycle.
// - Clear polarity 0 triggers on falling, 1 on rising edge.
// - Comparator still active at cycle start keeps output low.
// - Match or up edge drives high; overflow or down drives low.
// - Cycle overflow flag tracks counter bit N overflow; software clears.
module pwm_top
  import pca_pwm_pkg::*;
(
  input wire logic clk_i,             // System clock, 40 MHz
  input wire logic rst_b_i,           // Async reset, active low
  input wire logic count_tick_i,      // Counter timebase pulse
  input wire sfr_byte_t sfr_addr_i,   // Register address
  input wire sfr_byte_t sfr_wdata_i,  // Register write data
  input wire logic sfr_wr_i,          // Register write strobe
  input wire logic sfr_rd_i,          // Register read strobe
  output sfr_byte_t sfr_rdata_o,      // Register read data
  input wire sfr_byte_t bit_addr_i,   // Bit address
  input wire logic bit_wdata_i,       // Bit write value
  input wire logic bit_wr_i,          // Bit write strobe
  input wire logic cf_irq_en_i,       // Counter overflow interrupt enable
  input wire logic cmp_async_i,       // Comparator output, asynchronous
  output logic [2:0] channel_output_o, // PWM channel pins
  output logic irq_o                  // Interrupt request
);

  logic [16:0] ctr_r;
  logic [16:0] cnt_nxt;
  logic tick_ev;
  cmp_word_t cp_r [3];
  cmp_word_t ar_r [3];
  sfr_byte_t mode_r [3];
  logic [2:0] center_r;
  logic [2:0] cpce_r;
  logic clr_pol_r;
  logic cf_r;
  logic cr_r;
  logic [2:0] ccf_r;
  logic reload_view_select_r;
  logic ecov_r;
  logic cycle_overflow_flag_r;
  logic [2:0] cls_r;
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic cmp_s3_r;
  logic cmp_lvl_r;
  logic cmp_lvl_d_r;
  logic cmp_rise;
  logic cmp_fall;
  sfr_byte_t rdata_r;
  logic [2:0] set_ev;
  logic [2:0] clr_ev;
  logic [2:0] wide;
  logic [2:0] narrow;
  logic [2:0] mode8;
  logic [2:0] mode_ext;
  logic [2:0] wr_lo;
  logic [2:0] wr_hi;
  logic [2:0] wr_cpm;
  logic [2:0] ccf_set;
  logic cf_set;
  logic cycle_overflow_flag_set;
  logic ctrl_wr;
  logic ctrl_bit_wr;
  res_t shared_res;

  function automatic sfr_byte_t cpl_addr(input int ch);
    case (ch)
      0: cpl_addr = `CPL0_ADDR;
      1: cpl_addr = `CPL1_ADDR;
      default: cpl_addr = `CPL2_ADDR;
    endcase
  endfunction : cpl_addr

  function automatic sfr_byte_t cph_addr(input int ch);
    case (ch)
      0: cph_addr = `CPH0_ADDR;
      1: cph_addr = `CPH1_ADDR;
      default: cph_addr = `CPH2_ADDR;
    endcase
  endfunction : cph_addr

  function automatic sfr_byte_t cpm_addr(input int ch);
    case (ch)
      0: cpm_addr = `CPM0_ADDR;
      1: cpm_addr = `CPM1_ADDR;
      default: cpm_addr = `CPM2_ADDR;
    endcase
  endfunction : cpm_addr

  assign tick_ev = cr_r && count_tick_i;
  assign cnt_nxt = ctr_r + 17'h00001;
  assign shared_res = `RES_BASE + {3'b000, cls_r[1:0]};
  assign ctrl_wr = sfr_wr_i && (sfr_addr_i == `CTRL_ADDR);
  assign ctrl_bit_wr = bit_wr_i && (bit_addr_i[7:3] == `CTRL_BIT_BASE);

  // Counter with a hidden 17th bit for wide center-aligned operation
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctr_r <= `CTR_RST;
    end else if (tick_ev) begin
      ctr_r <= cnt_nxt;
    end
  end

  // Comparator synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      cmp_s3_r <= 1'b0;
      cmp_lvl_r <= 1'b0;
      cmp_lvl_d_r <= 1'b0;
    end else begin
      cmp_s1_r <= cmp_async_i;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
      if (cmp_s2_r == cmp_s3_r) begin
        cmp_lvl_r <= cmp_s3_r;
      end
      cmp_lvl_d_r <= cmp_lvl_r;
    end
  end

  assign cmp_rise = cmp_lvl_r && !cmp_lvl_d_r;
  assign cmp_fall = !cmp_lvl_r && cmp_lvl_d_r;

  for (genvar i = 0; i < 3; i++) begin : g_ch
    res_t res;
    assign wide[i] = mode_r[i][`CPM_WIDE_BIT];
    assign narrow[i] = mode_r[i][`CPM_PWM_BIT] && !wide[i];
    assign mode8[i] = narrow[i] && mode_r[i][`CPM_ECOM_BIT]
                      && (cls_r == 3'b000);
    assign mode_ext[i] = narrow[i] && mode_r[i][`CPM_ECOM_BIT]
                         && (cls_r != 3'b000);
    assign res = wide[i] ? `RES_WIDE : shared_res;
    assign wr_lo[i] = sfr_wr_i && (sfr_addr_i == cpl_addr(i));
    assign wr_hi[i] = sfr_wr_i && (sfr_addr_i == cph_addr(i));
    assign wr_cpm[i] = sfr_wr_i && (sfr_addr_i == cpm_addr(i));
    assign ccf_set[i] = set_ev[i] && mode_r[i][`CPM_MAT_BIT];

    pwm_channel u_chan (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(tick_ev),
      .cnt_nxt_i(cnt_nxt),
      .res_i(res),
      .match_en_i(mode_r[i][`CPM_ECOM_BIT] && mode_r[i][`CPM_PWM_BIT]),
      .pwm_en_i(mode_r[i][`CPM_PWM_BIT]),
      .center_i(center_r[i]),
      .cp_i(cp_r[i]),
      .clr_en_i(cpce_r[i]),
      .clr_pol_i(clr_pol_r),
      .cmp_level_i(cmp_lvl_r),
      .cmp_rise_i(cmp_rise),
      .cmp_fall_i(cmp_fall),
      .set_ev_o(set_ev[i]),
      .clr_ev_o(clr_ev[i]),
      .out_o(channel_output_o[i])
    );

    // Compare and reload storage; a firmware write beats the reload
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        cp_r[i] <= `WORD_RST;
        ar_r[i] <= `WORD_RST;
      end else if (wr_lo[i] || wr_hi[i]) begin
        if (reload_view_select_r) begin
          if (wr_lo[i]) ar_r[i][7:0] <= sfr_wdata_i;
          else ar_r[i][15:8] <= sfr_wdata_i;
        end else begin
          if (wr_lo[i]) cp_r[i][7:0] <= sfr_wdata_i;
          else cp_r[i][15:8] <= sfr_wdata_i;
        end
      end else if (mode8[i] && (center_r[i] ? set_ev[i] : clr_ev[i])) begin
        cp_r[i][7:0] <= cp_r[i][15:8];
      end else if (mode_ext[i]
                   && (center_r[i] ? set_ev[i] : clr_ev[i])) begin
        cp_r[i] <= ar_r[i];
      end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        mode_r[i] <= `BYTE_RST;
      end else if (wr_cpm[i]) begin
        mode_r[i] <= sfr_wdata_i;
      end else if (wr_lo[i]) begin
        mode_r[i][`CPM_ECOM_BIT] <= 1'b0;
      end else if (wr_hi[i]) begin
        mode_r[i][`CPM_ECOM_BIT] <= 1'b1;
      end
    end
  end

  assign cf_set = (tick_ev && (ctr_r[15:0] == 16'hFFFF))
                  || |(clr_ev & wide & center_r);
  assign cycle_overflow_flag_set = (tick_ev
                     && ((cnt_nxt[15:0] & res_mask(shared_res))
                         == 16'h0000))
                    || |(clr_ev & narrow);

  // Status flags: hardware set is ORed after the software value
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cf_r <= 1'b0;
      cr_r <= 1'b0;
      ccf_r <= 3'b000;
    end else begin
      if (ctrl_wr) begin
        cf_r <= sfr_wdata_i[`CTRL_CF_BIT] || cf_set;
        cr_r <= sfr_wdata_i[`CTRL_CR_BIT];
        ccf_r <= sfr_wdata_i[2:0] | ccf_set;
      end else if (ctrl_bit_wr) begin
        cf_r <= ((bit_addr_i[2:0] == 3'd7) ? bit_wdata_i : cf_r) || cf_set;
        cr_r <= (bit_addr_i[2:0] == 3'd6) ? bit_wdata_i : cr_r;
        for (int b = 0; b < 3; b++) begin
          ccf_r[b] <= ((bit_addr_i[2:0] == 3'(b)) ? bit_wdata_i : ccf_r[b])
                      || ccf_set[b];
        end
      end else begin
        cf_r <= cf_r || cf_set;
        ccf_r <= ccf_r | ccf_set;
      end
    end
  end

  // Cycle length, reload view and cycle overflow flag
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reload_view_select_r <= 1'b0;
      ecov_r <= 1'b0;
      cycle_overflow_flag_r <= 1'b0;
      cls_r <= 3'b000;
    end else if (sfr_wr_i && (sfr_addr_i == `PWMCFG_ADDR)) begin
      reload_view_select_r <= sfr_wdata_i[`PWM_RELOAD_VIEW_SELECT_BIT];
      ecov_r <= sfr_wdata_i[`PWM_ECOV_BIT];
      cycle_overflow_flag_r <= sfr_wdata_i[`PWM_CYCLE_OVERFLOW_FLAG_BIT] || cycle_overflow_flag_set;
      cls_r <= sfr_wdata_i[2:0];
    end else begin
      cycle_overflow_flag_r <= cycle_overflow_flag_r || cycle_overflow_flag_set;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpce_r <= 3'b000;
      clr_pol_r <= 1'b0;
      center_r <= 3'b000;
    end else begin
      if (sfr_wr_i && (sfr_addr_i == `CLRCFG_ADDR)) begin
        cpce_r <= sfr_wdata_i[2:0];
        clr_pol_r <= sfr_wdata_i[`CLR_POL_BIT];
      end
      if (sfr_wr_i && (sfr_addr_i == `ALIGN_ADDR)) begin
        center_r <= sfr_wdata_i[2:0];
      end
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= `BYTE_RST;
    end else if (sfr_rd_i) begin
      rdata_r <= `BYTE_RST;
      if (sfr_addr_i == `CTRL_ADDR) begin
        rdata_r <= {cf_r, cr_r, 3'b000, ccf_r};
      end else if (sfr_addr_i == `PWMCFG_ADDR) begin
        rdata_r <= {reload_view_select_r, ecov_r, cycle_overflow_flag_r, 2'b00, cls_r};
      end else if (sfr_addr_i == `CLRCFG_ADDR) begin
        rdata_r <= {clr_pol_r, 4'h0, cpce_r};
      end else if (sfr_addr_i == `ALIGN_ADDR) begin
        rdata_r <= {5'h00, center_r};
      end
      for (int c = 0; c < 3; c++) begin
        if (sfr_addr_i == cpm_addr(c)) rdata_r <= mode_r[c];
        if (sfr_addr_i == cpl_addr(c)) begin
          rdata_r <= reload_view_select_r ? ar_r[c][7:0] : cp_r[c][7:0];
        end
        if (sfr_addr_i == cph_addr(c)) begin
          rdata_r <= reload_view_select_r ? ar_r[c][15:8] : cp_r[c][15:8];
        end
      end
    end
  end

  assign sfr_rdata_o = rdata_r;

  always_comb begin
    irq_o = (cf_r && cf_irq_en_i) || (cycle_overflow_flag_r && ecov_r);
    for (int k = 0; k < 3; k++) begin
      irq_o = irq_o || (ccf_r[k] && mode_r[k][`CPM_ECCF_BIT]);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_low_write;
    sfr_wr_i && (sfr_addr_i == `CPL0_ADDR);
  endsequence
  sequence s_high_write;
    sfr_wr_i && (sfr_addr_i == `CPH0_ADDR);
  endsequence
  sequence s_clear_trig;
    cpce_r[0] && mode_r[0][`CPM_PWM_BIT]
    && (clr_pol_r ? cmp_rise : cmp_fall);
  endsequence

  property p_low_clears_ecom;
    s_low_write |=> !mode_r[0][`CPM_ECOM_BIT];
  endproperty
  a_low_clears_ecom: assert property (p_low_clears_ecom)
    else $error("low byte write left compare enable set");

  property p_high_sets_ecom;
    s_high_write |=> mode_r[0][`CPM_ECOM_BIT];
  endproperty
  a_high_sets_ecom: assert property (p_high_sets_ecom)
    else $error("high byte write did not set compare enable");

  property p_cf_wrap;
    tick_ev && (ctr_r[15:0] == 16'hFFFF) |=> cf_r && (ctr_r[15:0] == 16'h0000);
  endproperty
  a_cf_wrap: assert property (p_cf_wrap)
    else $error("counter wrap did not set overflow flag");

  property p_run_stop;
    !cr_r |=> $stable(ctr_r);
  endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("counter moved while stopped");

  property p_ccf_set;
    set_ev[0] && mode_r[0][`CPM_MAT_BIT] |=> ccf_r[0];
  endproperty
  a_ccf_set: assert property (p_ccf_set)
    else $error("match edge did not set event flag");

  property p_ccf_sticky;
    ccf_r[0] && !ctrl_wr && !ctrl_bit_wr |=> ccf_r[0];
  endproperty
  a_ccf_sticky: assert property (p_ccf_sticky)
    else $error("event flag cleared by hardware");

  property p_reload_ext;
    mode_ext[0] && !center_r[0] && clr_ev[0] && !wr_lo[0] && !wr_hi[0]
      |=> cp_r[0] == $past(ar_r[0]);
  endproperty
  a_reload_ext: assert property (p_reload_ext)
    else $error("reload value not copied at overflow edge");

  property p_clear_low;
    s_clear_trig |=> !channel_output_o[0] [*2];
  endproperty
  a_clear_low: assert property (p_clear_low)
    else $error("comparator clear did not hold output low");

  property p_cycle_overflow_flag;
    narrow[0] && clr_ev[0] |=> cycle_overflow_flag_r;
  endproperty
  a_cycle_overflow_flag: assert property (p_cycle_overflow_flag)
    else $error("narrow overflow did not set cycle overflow flag");

  property p_set_wins;
    ctrl_wr && !sfr_wdata_i[0] && ccf_set[0] |=> ccf_r[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("software clear swallowed a hardware set");

endmodule : pwm_top

// ===== dv/pwm_load.sv
`timescale 1ns/1ps

// Load on the three pins; counts high cycles so duty is measured, not seen
module pwm_load (
  input wire logic clk_i,             // System clock
  input wire logic rst_b_i,           // Async reset, active low
  input wire logic clr_i,             // Restart the counts
  input wire logic [2:0] pin_i,       // PWM pins
  output logic [2:0][15:0] high_cnt_o // High cycles since restart
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      high_cnt_o <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (clr_i) begin
          high_cnt_o[i] <= 16'h0000;
        end else begin
          high_cnt_o[i] <= high_cnt_o[i] + {15'h0000, pin_i[i]};
        end
      end
    end
  end
endmodule : pwm_load

// ===== dv/test_pwm_top.sv
`timescale 1ns/1ps
`include "pca_pwm_defines.svh"

module test_pwm_top
  import pca_pwm_pkg::*;
;

  logic clk, rst_b, tick, wr_s, rd_s, bit_val, bit_wr, cf_irq_en, cmp;
  logic irq, clr, rd_seen;
  sfr_byte_t addr, wdata, rdata, bit_addr;
  logic [2:0] pins;
  logic [2:0][15:0] high_cnt;
  sfr_byte_t exp_q[$];
  logic [7:0] duty;
  int errors, num_checks, n;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  pwm_top u_dut (
    .clk_i(clk), .rst_b_i(rst_b), .count_tick_i(tick),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr_s),
    .sfr_rd_i(rd_s), .sfr_rdata_o(rdata), .bit_addr_i(bit_addr),
    .bit_wdata_i(bit_val), .bit_wr_i(bit_wr), .cf_irq_en_i(cf_irq_en),
    .cmp_async_i(cmp), .channel_output_o(pins), .irq_o(irq)
  );

  pwm_load u_load (
    .clk_i(clk), .rst_b_i(rst_b), .clr_i(clr), .pin_i(pins),
    .high_cnt_o(high_cnt)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask : note

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
    #2;
  endtask : wait_cyc

  task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
    wait_cyc(1);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    wait_cyc(1);
    wr_s = 1'b0;
  endtask : wr

  // Expected byte is queued; the monitor compares when the data lands
  task automatic rd(input sfr_byte_t a, input sfr_byte_t e);
    wait_cyc(1);
    addr = a;
    rd_s = 1'b1;
    exp_q.push_back(e);
    wait_cyc(1);
    rd_s = 1'b0;
  endtask : rd

  task automatic bitwr(input logic [2:0] b, input logic v);
    wait_cyc(1);
    bit_addr = {`CTRL_BIT_BASE, b};
    bit_val = v;
    bit_wr = 1'b1;
    wait_cyc(1);
    bit_wr = 1'b0;
  endtask : bitwr

  task automatic meas(input int ch, input logic [15:0] e, input int len);
    clr = 1'b1;
    wait_cyc(1);
    clr = 1'b0;
    wait_cyc(len);
    check(high_cnt[ch], e);
  endtask : meas

  always @(posedge clk) rd_seen <= rd_s;

  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    end_of_test();
  end

  initial begin
    {addr, wdata, wr_s, rd_s, bit_addr, bit_val, bit_wr, clr} = '0;
    rst_b = 1'b0;
    tick = 1'b1;
    cf_irq_en = 1'b0;
    cmp = 1'b1;
    errors = 0;
    num_checks = 0;
    void'($urandom(32'h41327EF2));
    repeat (2) @(posedge clk);
    #2;
    rst_b = 1'b1;
    rd(`CTRL_ADDR, 8'h00);
    rd(8'h80, 8'h00);
    bitwr(3'h6, 1'b1);
    bitwr(3'h4, 1'b0);
    rd(`CTRL_ADDR, 8'h40);
    note("control");
    // Same duty in both bytes so a low-byte reload cannot move it
    duty = 8'($urandom_range(255, 1));
    wr(`CPM0_ADDR, 8'h4A);
    wr(`CPL0_ADDR, duty);
    rd(`CPM0_ADDR, 8'h0A);
    wr(`CPH0_ADDR, duty);
    rd(`CPM0_ADDR, 8'h4A);
    wait_cyc(300);
    meas(0, 16'h0100 - {8'h00, duty}, 256);
    rd(`PWMCFG_ADDR, 8'h20);
    rd(`CTRL_ADDR, 8'h41);
    note("eight_bit");
    wr(`PWMCFG_ADDR, 8'h81);
    wr(`CPL0_ADDR, 8'h40);
    wr(`CPH0_ADDR, 8'hFE);
    rd(`CPL0_ADDR, 8'h40);
    rd(`CPH0_ADDR, 8'hFE);
    wr(`PWMCFG_ADDR, 8'h01);
    wait_cyc(600);
    rd(`CPL0_ADDR, 8'h40);
    rd(`CPH0_ADDR, 8'hFE);
    rd(`PWMCFG_ADDR, 8'h21);
    meas(0, 16'h01C0, 512);
    note("nine_bit");
    for (int p = 0; p < 2; p++) begin
      cmp = ~p[0];
      wr(`CLRCFG_ADDR, {p[0], 7'h01});
      wait_cyc(1100);
      meas(0, 16'h01C0, 512);
      cmp = p[0];
      wait_cyc(600);
      meas(0, 16'h0000, 512);
      cmp = ~p[0];
      wait_cyc(1100);
      meas(0, 16'h01C0, 512);
    end
    wr(`CLRCFG_ADDR, 8'h00);
    note("comparator_clear");
    // Channel 2 center-aligned at 9 bits, duty set through the reload view
    wr(`ALIGN_ADDR, 8'h04);
    wr(`PWMCFG_ADDR, 8'h81);
    wr(`CPM2_ADDR, 8'h42);
    wr(`CPL2_ADDR, 8'h40);
    wr(`CPH2_ADDR, 8'h00);
    wr(`PWMCFG_ADDR, 8'h01);
    wait_cyc(1100);
    rd(`CPL2_ADDR, 8'h40);
    meas(2, 16'h037E, 1024);
    note("center");
    wr(`CPM1_ADDR, 8'hCA);
    wr(`CPL1_ADDR, 8'h00);
    wr(`CPH1_ADDR, 8'hFF);
    n = 0;
    while (pins[1] !== 1'b1 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (pins[1] === 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check(16'(n), 16'h0100);
    wait_cyc(1);
    check({15'h0000, irq}, 16'h0000);
    cf_irq_en = 1'b1;
    wait_cyc(1);
    check({15'h0000, irq}, 16'h0001);
    rd(`CTRL_ADDR, 8'hC3);
    // Match interrupt enabled so wide duty updates can follow the flag
    wr(`CPM1_ADDR, 8'hCB);
    cf_irq_en = 1'b0;
    wait_cyc(1);
    check({15'h0000, irq}, 16'h0001);
    note("wide");
    wait_cyc(2);
    end_of_test();
  end
endmodule : test_pwm_top
